// ==== rtl/sfr_bank.sv ====
// Overview of operation
// - stack pointer resets 07, pre-increments on push
// - 16-bit program counter, zero reset, counts fetches
// - status bits 4:3 pick register bank
// - status bit 0 tracks accumulator parity
// - status carry, aux, user, overflow, user1 bits
// - data pointer loads whole or by byte
// - port latch bit drives its pin level
// - direction bit one makes pin output
// - port read returns actual pin level
// - ports 0,1 eight pins, port 2 six
// - code 55 starts page erase
// - code AA mass erase needs arm, debug
// - other erase codes ignored, trigger reads 00
// - page select holds 0 to 127
// - control write of 01 launches eeprom transmit
// - program write enable defaults zero
// - baud control implements only bit 7
// - movx high byte register resets zero
// - helper register for multiply and divide
// - unmapped reads zero, writes ignored
module sfr_bank (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire sfr_bank_pkg::core_evt_t core_evt_in,
  input wire logic debug_en_in,
  input wire logic [21:0] pin_in,
  output logic [21:0] pin_out,
  output logic [21:0] pin_oe_out,
  output logic [7:0] rdata_out,
  output logic [1:0] reg_bank_out,
  output logic [15:0] data_pointer16_out,
  output logic [7:0] stack_top_pointer_out,
  output logic [15:0] instruction_counter_out,
  output logic [7:0] movx_high_address_byte_out,
  output logic program_space_write_enable_out,
  output logic baud_source_out,
  output sfr_bank_pkg::flash_cmd_t flash_cmd_out
);
  import sfr_bank_pkg::*;

  bank_state_t st_r;
  bank_state_t st_nxt;
  logic [21:0] pin_meta_r;
  logic [21:0] pin_sync_r;
  sfr_req_t req;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else if (clk_en_in)
    begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.page_go = 1'b0;
    st_nxt.mass_go = 1'b0;
    st_nxt.ee_go = 1'b0;
    st_nxt.erase = ERASE_IDLE;
    if (core_evt_in.push)
      st_nxt.stack = st_r.stack + 8'h01;
    if (core_evt_in.fetch)
      st_nxt.pc = st_r.pc + 16'h0001;
    if (core_evt_in.data_pointer16_load)
    begin
      st_nxt.data_pointer_high = core_evt_in.data_pointer16_value[15:8];
      st_nxt.data_pointer_low = core_evt_in.data_pointer16_value[7:0];
    end
    if (core_evt_in.muldiv_load)
      st_nxt.muldiv = core_evt_in.muldiv_value;
    if (core_evt_in.acc_load)
      st_nxt.acc = core_evt_in.acc_value;
    if (req.wr)
    begin
      case (req.addr)
        ADDR_PORT0: st_nxt.port0 = req.wdata;
        ADDR_PORT1: st_nxt.port1 = req.wdata;
        ADDR_PORT2: st_nxt.port2 = req.wdata[PORT2_PINS-1:0];
        ADDR_PORT0_OUTPUT_SELECT: st_nxt.port0_output_select = req.wdata;
        ADDR_PORT1_OUTPUT_SELECT: st_nxt.port1_output_select = req.wdata;
        ADDR_PORT2_OUTPUT_SELECT: st_nxt.port2_output_select = req.wdata[PORT2_PINS-1:0];
        ADDR_STACK: st_nxt.stack = req.wdata;
        ADDR_DPL: st_nxt.data_pointer_low = req.wdata;
        ADDR_DPH: st_nxt.data_pointer_high = req.wdata;
        ADDR_SERIAL_EEPROM_DATA: st_nxt.serial_eeprom_data = req.wdata;
        ADDR_SERIAL_EEPROM_CONTROL:
        begin
          st_nxt.serial_eeprom_control = req.wdata;
          st_nxt.ee_go = (req.wdata == EE_TX_CODE);
        end
        ADDR_FLCTL:
        begin
          st_nxt.pwe = req.wdata[FL_PWE];
          st_nxt.meen = req.wdata[FL_MEEN];
        end
        ADDR_PGSEL: st_nxt.pgsel = req.wdata[6:0];
        ADDR_MOVXHI: st_nxt.movxhi = req.wdata;
        ADDR_IRQCTL: st_nxt.irqctl = req.wdata;
        ADDR_PSW: st_nxt.program_status_word = req.wdata;
        ADDR_BAUD: st_nxt.baud = req.wdata[BAUD_BIT];
        ADDR_ACC: st_nxt.acc = req.wdata;
        ADDR_MULDIV: st_nxt.muldiv = req.wdata;
        ADDR_ERASE:
        begin
          case (req.wdata)
            ERASE_PAGE_CODE:
            begin
              st_nxt.page_go = 1'b1;
              st_nxt.erase = ERASE_PAGE;
            end
            ERASE_MASS_CODE:
            begin
              if (st_r.meen && debug_en_in)
              begin
                st_nxt.mass_go = 1'b1;
                st_nxt.erase = ERASE_MASS;
                st_nxt.meen = 1'b0;
              end
            end
            default: st_nxt.erase = ERASE_IDLE;
          endcase
        end
        default: st_nxt.erase = ERASE_IDLE;
      endcase
    end
    // parity follows final accumulator value
    st_nxt.program_status_word[PSW_PARITY] = odd_ones(st_nxt.acc);
    st_nxt.rdata = st_r.rdata;
    if (req.rd)
    begin
      case (req.addr)
        ADDR_PORT0: st_nxt.rdata = pin_sync_r[7:0];
        ADDR_PORT1: st_nxt.rdata = pin_sync_r[15:8];
        ADDR_PORT2: st_nxt.rdata = {2'b00, pin_sync_r[21:16]};
        ADDR_PORT0_OUTPUT_SELECT: st_nxt.rdata = st_r.port0_output_select;
        ADDR_PORT1_OUTPUT_SELECT: st_nxt.rdata = st_r.port1_output_select;
        ADDR_PORT2_OUTPUT_SELECT: st_nxt.rdata = {2'b00, st_r.port2_output_select};
        ADDR_STACK: st_nxt.rdata = st_r.stack;
        ADDR_DPL: st_nxt.rdata = st_r.data_pointer_low;
        ADDR_DPH: st_nxt.rdata = st_r.data_pointer_high;
        ADDR_ERASE: st_nxt.rdata = ZERO_BYTE;
        ADDR_SERIAL_EEPROM_DATA: st_nxt.rdata = st_r.serial_eeprom_data;
        ADDR_SERIAL_EEPROM_CONTROL: st_nxt.rdata = st_r.serial_eeprom_control;
        ADDR_FLCTL: st_nxt.rdata = {6'h00, st_r.meen, st_r.pwe};
        ADDR_PGSEL: st_nxt.rdata = {1'b0, st_r.pgsel};
        ADDR_MOVXHI: st_nxt.rdata = st_r.movxhi;
        ADDR_IRQCTL: st_nxt.rdata = st_r.irqctl;
        ADDR_PSW: st_nxt.rdata = st_r.program_status_word;
        ADDR_BAUD: st_nxt.rdata = {st_r.baud, 7'h00};
        ADDR_ACC: st_nxt.rdata = st_r.acc;
        ADDR_MULDIV: st_nxt.rdata = st_r.muldiv;
        ADDR_PCLO: st_nxt.rdata = st_r.pc[7:0];
        ADDR_PCHI: st_nxt.rdata = st_r.pc[15:8];
        default: st_nxt.rdata = UNMAPPED_READ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= '0;
      st_r.port0 <= PORT01_RESET;
      st_r.port1 <= PORT01_RESET;
      st_r.stack <= STACK_RESET;
      st_r.pc <= PC_RESET;
      st_r.pgsel <= PAGE_MAX & 7'h00;
      st_r.movxhi <= ZERO_BYTE;
      st_r.erase <= ERASE_IDLE;
    end
    else if (clk_en_in)
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pin_out = {st_r.port2, st_r.port1, st_r.port0};
  assign pin_oe_out = {st_r.port2_output_select, st_r.port1_output_select, st_r.port0_output_select};
  assign rdata_out = st_r.rdata;
  assign reg_bank_out = {st_r.program_status_word[PSW_BANK_HI], st_r.program_status_word[PSW_BANK_LO]};
  assign data_pointer16_out = {st_r.data_pointer_high, st_r.data_pointer_low};
  assign stack_top_pointer_out = st_r.stack;
  assign instruction_counter_out = st_r.pc;
  assign movx_high_address_byte_out = st_r.movxhi;
  assign program_space_write_enable_out = st_r.pwe;
  assign baud_source_out = st_r.baud;
  assign flash_cmd_out = '{page_erase: st_r.page_go,
                           mass_erase: st_r.mass_go,
                           ee_transmit: st_r.ee_go,
                           page: st_r.pgsel};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_push_inc;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    clk_en_in && core_evt_in.push && !wr_in
      |=> st_r.stack == $past(st_r.stack) + 8'h01;
  endproperty
  a_push_inc: assert property (p_push_inc)
    else $error("stack did not pre-increment");

  property p_pc_inc;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    clk_en_in && core_evt_in.fetch
      |=> instruction_counter_out == $past(st_r.pc) + 16'h0001;
  endproperty
  a_pc_inc: assert property (p_pc_inc)
    else $error("program counter did not advance");

  property p_bank;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    clk_en_in && wr_in && addr_in == ADDR_PSW
      |=> reg_bank_out == $past(wdata_in[PSW_BANK_HI:PSW_BANK_LO]);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank select mismatch");

  property p_parity;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    st_r.program_status_word[0] == ^st_r.acc;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity flag wrong");

  // page erase request seen on the bus this cycle
  logic page_cmd;
  assign page_cmd = clk_en_in && wr_in && addr_in == ADDR_ERASE &&
    wdata_in == ERASE_PAGE_CODE;

  property p_page_erase;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    page_cmd |=> flash_cmd_out.page_erase ##1
      (!flash_cmd_out.page_erase || $past(page_cmd) || !$past(clk_en_in));
  endproperty
  a_page_erase: assert property (p_page_erase)
    else $error("page erase not pulsed");

  property p_mass_guard;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(flash_cmd_out.mass_erase) |-> $past(st_r.meen) &&
      $past(debug_en_in) && $past(wdata_in) == ERASE_MASS_CODE;
  endproperty
  a_mass_guard: assert property (p_mass_guard)
    else $error("mass erase without arm");

  property p_other_code;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    clk_en_in && wr_in && addr_in == ADDR_ERASE &&
      wdata_in != ERASE_PAGE_CODE && wdata_in != ERASE_MASS_CODE
      |=> !flash_cmd_out.page_erase && !flash_cmd_out.mass_erase;
  endproperty
  a_other_code: assert property (p_other_code)
    else $error("erase from bad code");

  property p_port_read;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    clk_en_in && rd_in && addr_in == ADDR_PORT0
      |=> rdata_out == $past(pin_sync_r[7:0]);
  endproperty
  a_port_read: assert property (p_port_read)
    else $error("port read not pin level");

  property p_ee_go;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    clk_en_in && wr_in && addr_in == ADDR_SERIAL_EEPROM_CONTROL && wdata_in == EE_TX_CODE
      |=> flash_cmd_out.ee_transmit;
  endproperty
  a_ee_go: assert property (p_ee_go)
    else $error("eeprom transmit not launched");

  property p_unmapped;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    clk_en_in && rd_in && addr_in == 8'hC8 |=> rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

endmodule

// ==== shared/sfr_bank_pkg.sv ====
package sfr_bank_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_STACK = 8'h81;
  localparam logic [7:0] ADDR_DPL = 8'h82;
  localparam logic [7:0] ADDR_DPH = 8'h83;
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_PORT1_OUTPUT_SELECT = 8'h91;
  localparam logic [7:0] ADDR_ERASE = 8'h94;
  localparam logic [7:0] ADDR_SERIAL_EEPROM_DATA = 8'h9E;
  localparam logic [7:0] ADDR_SERIAL_EEPROM_CONTROL = 8'h9F;
  localparam logic [7:0] ADDR_PORT2 = 8'hA0;
  localparam logic [7:0] ADDR_PORT2_OUTPUT_SELECT = 8'hA1;
  localparam logic [7:0] ADDR_PORT0_OUTPUT_SELECT = 8'hA2;
  localparam logic [7:0] ADDR_FLCTL = 8'hB2;
  localparam logic [7:0] ADDR_PGSEL = 8'hB7;
  localparam logic [7:0] ADDR_MOVXHI = 8'hBF;
  localparam logic [7:0] ADDR_IRQCTL = 8'hC0;
  localparam logic [7:0] ADDR_PSW = 8'hD0;
  localparam logic [7:0] ADDR_BAUD = 8'hD8;
  localparam logic [7:0] ADDR_ACC = 8'hE0;
  localparam logic [7:0] ADDR_MULDIV = 8'hF0;
  localparam logic [7:0] ADDR_PCLO = 8'hFC;
  localparam logic [7:0] ADDR_PCHI = 8'hFD;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] STACK_RESET = 8'h07;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] PORT01_RESET = 8'hFF;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] ERASE_PAGE_CODE = 8'h55;
  localparam logic [7:0] ERASE_MASS_CODE = 8'hAA;
  localparam logic [7:0] EE_TX_CODE = 8'h01;
  localparam logic [6:0] PAGE_MAX = 7'h7F;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PSW_CARRY = 7;
  localparam int PSW_AUX = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_BANK_HI = 4;
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_USER1 = 1;
  localparam int PSW_PARITY = 0;
  localparam int FL_PWE = 0;
  localparam int FL_MEEN = 1;
  localparam int BAUD_BIT = 7;
  localparam int PORT2_PINS = 6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfr_req_t;

  typedef struct packed {
    logic push;
    logic fetch;
    logic data_pointer16_load;
    logic [15:0] data_pointer16_value;
    logic muldiv_load;
    logic [7:0] muldiv_value;
    logic acc_load;
    logic [7:0] acc_value;
  } core_evt_t;

  typedef struct packed {
    logic page_erase;
    logic mass_erase;
    logic ee_transmit;
    logic [6:0] page;
  } flash_cmd_t;

  typedef enum logic [1:0] {
    ERASE_IDLE,
    ERASE_PAGE,
    ERASE_MASS
  } erase_state_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] port0;
    logic [7:0] port1;
    logic [5:0] port2;
    logic [7:0] port0_output_select;
    logic [7:0] port1_output_select;
    logic [5:0] port2_output_select;
    logic [7:0] stack;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [15:0] pc;
    logic [7:0] serial_eeprom_data;
    logic [7:0] serial_eeprom_control;
    logic pwe;
    logic meen;
    logic [6:0] pgsel;
    logic [7:0] movxhi;
    logic [7:0] irqctl;
    logic [7:0] program_status_word;
    logic baud;
    logic [7:0] acc;
    logic [7:0] muldiv;
    logic page_go;
    logic mass_go;
    logic ee_go;
    erase_state_t erase;
  } bank_state_t;

  function automatic logic odd_ones(input logic [7:0] v);
    odd_ones = ^v;
  endfunction

endpackage

// ==== test/sfr_bank_tb.sv ====
module sfr_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sfr_bank_pkg::*;

  // ------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  core_evt_t core_evt_in = '0;
  logic debug_en_in = 1'b0;
  logic [21:0] ext_lvl = 22'h000000;
  logic [21:0] pin_in;
  logic [21:0] pin_out;
  logic [21:0] pin_oe_out;
  logic [7:0] rdata_out;
  logic [1:0] reg_bank_out;
  logic [15:0] data_pointer16_out;
  logic [7:0] stack_top_pointer_out;
  logic [15:0] instruction_counter_out;
  logic [7:0] movx_high_address_byte_out;
  logic program_space_write_enable_out;
  logic baud_source_out;
  flash_cmd_t flash_cmd_out;
  logic [7:0] d;
  int errors = 0;
  int num_checks = 0;
  int n_page = 0;
  int n_mass = 0;
  int n_ee = 0;
  int i;
  logic [7:0] bad_codes [6] = '{8'h00, 8'h54, 8'h56, 8'hA9, 8'hAB, 8'hFF};

  // pin level: driven bits follow the latch, others the outside
  assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & ext_lvl);

  always #12.5 sys_clk_in = ~sys_clk_in;

  sfr_bank i_sfr_bank (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .core_evt_in(core_evt_in),
    .debug_en_in(debug_en_in),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out),
    .rdata_out(rdata_out),
    .reg_bank_out(reg_bank_out),
    .data_pointer16_out(data_pointer16_out),
    .stack_top_pointer_out(stack_top_pointer_out),
    .instruction_counter_out(instruction_counter_out),
    .movx_high_address_byte_out(movx_high_address_byte_out),
    .program_space_write_enable_out(program_space_write_enable_out),
    .baud_source_out(baud_source_out),
    .flash_cmd_out(flash_cmd_out)
  );

  // pulse counters
  always @(negedge sys_clk_in)
  begin
    if (flash_cmd_out.page_erase === 1'b1) n_page++;
    if (flash_cmd_out.mass_erase === 1'b1) n_mass++;
    if (flash_cmd_out.ee_transmit === 1'b1) n_ee++;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    @(negedge sys_clk_in);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    @(negedge sys_clk_in);
    v = rdata_out;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk({8'h00, v}, {8'h00, exp}, "read");
  endtask

  task automatic ev(input core_evt_t e);
    @(posedge sys_clk_in);
    core_evt_in <= e;
    @(posedge sys_clk_in);
    core_evt_in <= '0;
    @(negedge sys_clk_in);
  endtask

  initial
  begin
    #(25 * 20000);
    errors++;
    $display("mismatch at %0t: timeout", $time);
    end_sim();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    core_evt_t e;
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(negedge sys_clk_in);
    chk({8'h00, stack_top_pointer_out}, 16'h0007, "sp rst");
    chk(instruction_counter_out, 16'h0000, "pc rst");
    chk({14'h0, pin_oe_out[21:20]}, 16'h0000, "oe rst");
    chk({8'h00, movx_high_address_byte_out}, 16'h0000, "hi");
    chk({15'h0, program_space_write_enable_out}, 16'h0, "pwe");
    chk({15'h0, baud_source_out}, 16'h0000, "baud rst");
    rchk(ADDR_PGSEL, 8'h00);
    rchk(ADDR_ERASE, 8'h00);
    rchk(ADDR_PSW, 8'h00);
    rchk(ADDR_MULDIV, 8'h00);
    rchk(ADDR_IRQCTL, 8'h00);
    // stack and program counter
    e = '0;
    e.push = 1'b1;
    ev(e);
    chk({8'h00, stack_top_pointer_out}, 16'h0008, "push");
    rchk(ADDR_STACK, 8'h08);
    // clock enable low freezes the stack
    @(posedge sys_clk_in);
    clk_en_in <= 1'b0;
    ev(e);
    @(posedge sys_clk_in);
    clk_en_in <= 1'b1;
    @(negedge sys_clk_in);
    chk({8'h00, stack_top_pointer_out}, 16'h0008, "frozen");
    e = '0;
    e.fetch = 1'b1;
    for (i = 0; i < 3; i++) ev(e);
    chk(instruction_counter_out, 16'h0003, "fetch");
    rchk(ADDR_PCLO, 8'h03);
    rchk(ADDR_PCHI, 8'h00);
    // bank select codes
    for (i = 0; i < 4; i++)
    begin
      wr(ADDR_PSW, 8'(i << 3));
      chk({14'h0, reg_bank_out}, 16'(i), "bank");
    end
    // parity follows accumulator
    e = '0;
    e.acc_load = 1'b1;
    e.acc_value = 8'h01;
    ev(e);
    rchk(ADDR_PSW, 8'h19);
    wr(ADDR_ACC, 8'h03);
    rchk(ADDR_PSW, 8'h18);
    wr(ADDR_PSW, 8'hE7);
    rchk(ADDR_PSW, 8'hE6);
    wr(ADDR_ACC, 8'h07);
    rchk(ADDR_PSW, 8'hE7);
    // data pointer whole and by halves
    e = '0;
    e.data_pointer16_load = 1'b1;
    e.data_pointer16_value = 16'h1234;
    ev(e);
    chk(data_pointer16_out, 16'h1234, "dptr16");
    wr(ADDR_DPL, 8'h56);
    chk(data_pointer16_out, 16'h1256, "dpl");
    wr(ADDR_DPH, 8'h9A);
    chk(data_pointer16_out, 16'h9A56, "dph");
    rchk(ADDR_DPH, 8'h9A);
    // ports, direction and pin readback
    @(posedge sys_clk_in);
    ext_lvl <= 22'h2AC35A;
    wr(ADDR_PORT0, 8'hA5);
    wr(ADDR_PORT1, 8'h3C);
    wr(ADDR_PORT2, 8'hFF);
    chk({10'h0, pin_out[21:16]}, 16'h003F, "p2 pins");
    wr(ADDR_PORT2, 8'h15);
    wr(ADDR_PORT0_OUTPUT_SELECT, 8'hFF);
    wr(ADDR_PORT1_OUTPUT_SELECT, 8'hF0);
    wr(ADDR_PORT2_OUTPUT_SELECT, 8'h3F);
    chk(pin_out[15:0], 16'h3CA5, "latch");
    chk({10'h0, pin_out[21:16]}, 16'h0015, "p2 latch");
    chk(pin_oe_out[15:0], 16'hF0FF, "oe");
    chk({10'h0, pin_oe_out[21:16]}, 16'h003F, "oe2");
    rchk(ADDR_PORT1_OUTPUT_SELECT, 8'hF0);
    repeat (4) @(posedge sys_clk_in);
    rchk(ADDR_PORT0, 8'hA5);
    rchk(ADDR_PORT1, 8'h33);
    rd(ADDR_PORT2, d);
    chk({10'h0, d[5:0]}, 16'h0015, "p2 read");
    wr(ADDR_PORT0_OUTPUT_SELECT, 8'h00);
    repeat (4) @(posedge sys_clk_in);
    rchk(ADDR_PORT0, 8'h5A);
    // page select and erase codes
    wr(ADDR_PGSEL, 8'hFF);
    rchk(ADDR_PGSEL, 8'h7F);
    chk({9'h0, flash_cmd_out.page}, 16'h007F, "page");
    wr(ADDR_ERASE, ERASE_PAGE_CODE);
    repeat (2) @(posedge sys_clk_in);
    chk(16'(n_page), 16'h0001, "page erase");
    rchk(ADDR_ERASE, 8'h00);
    @(posedge sys_clk_in);
    debug_en_in <= 1'b1;
    foreach (bad_codes[k])
      wr(ADDR_ERASE, bad_codes[k]);
    wr(ADDR_ERASE, ERASE_MASS_CODE);
    repeat (2) @(posedge sys_clk_in);
    chk(16'(n_page + n_mass), 16'h0001, "no erase");
    wr(ADDR_FLCTL, 8'h02);
    wr(ADDR_ERASE, ERASE_MASS_CODE);
    wr(ADDR_ERASE, ERASE_MASS_CODE);
    @(posedge sys_clk_in);
    debug_en_in <= 1'b0;
    wr(ADDR_FLCTL, 8'h02);
    wr(ADDR_ERASE, ERASE_MASS_CODE);
    repeat (2) @(posedge sys_clk_in);
    chk(16'(n_mass), 16'h0001, "mass erase");
    // eeprom launch
    wr(ADDR_SERIAL_EEPROM_DATA, 8'h5A);
    rchk(ADDR_SERIAL_EEPROM_DATA, 8'h5A);
    wr(ADDR_SERIAL_EEPROM_CONTROL, EE_TX_CODE);
    repeat (2) @(posedge sys_clk_in);
    chk(16'(n_ee), 16'h0001, "ee tx");
    // control bytes, helper and unmapped
    wr(ADDR_FLCTL, 8'h01);
    chk({15'h0, program_space_write_enable_out}, 16'h1, "pwe");
    wr(ADDR_BAUD, 8'hFF);
    chk({15'h0, baud_source_out}, 16'h0001, "baud");
    rchk(ADDR_BAUD, 8'h80);
    wr(ADDR_MOVXHI, 8'h3C);
    chk({8'h0, movx_high_address_byte_out}, 16'h003C, "hi");
    rchk(ADDR_MOVXHI, 8'h3C);
    wr(ADDR_MULDIV, 8'h77);
    rchk(ADDR_MULDIV, 8'h77);
    e = '0;
    e.muldiv_load = 1'b1;
    e.muldiv_value = 8'h16;
    ev(e);
    rchk(ADDR_MULDIV, 8'h16);
    wr(8'hC8, 8'hFF);
    rchk(8'hC8, UNMAPPED_READ);
    rchk(ADDR_ACC, 8'h07);
    end_sim();
  end
endmodule
